// ---- rtl/metering_reset_init_sequencer.sv ----
`timescale 1ns/100ps

// Notes on behaviour
// R1: hardware reset holds clock, sync, selects high
// R2: reset release: remote reset low, eight toggles
// R3: clock resumes after remote reset returns high
// R4: reset-done reads zero during reset, then set
// R5: writing one clears reset-done, interrupt releases
// R6: interrupt unmaskable, low until flag cleared
// R7: hardware reset gives I2C, defaults, DSP idle
// R8: soft reset clears registers, keeps locked port
// R9: soft reset leaves DSP idle, self-clears
// R10: soft reset keeps converter clock running
// R11: remote-only reset bit self-clears after sequence
// R12: host polls remote reset bit until zero
// R13: clock-disable plus remote reset gives low power
// R14: host waits for interrupt low before init
// R15: host toggles slave select thrice for SPI
// R16: port lock write, cleared only by reset
// R17: host starts DSP writing run register
// R18: host writes last RAM register three times
// R19: two key writes enable RAM write protection
// R20: reading energy accumulator clears it
// R21: pulse-mode bits 9..11 disable pulse outputs
// R22: power-up waits 20 us with clock running
// R23: select low picks voltage, high picks temperature
// R24: divide-by-four counter, release outputs together
module metering_reset_init_sequencer
  import metering_seq_pkg::*;
(
  input  wire logic       clk_sys_in,
  input  wire logic       nrst_in,
  input  wire logic       supply_ok_in,
  input  wire logic       spi_request_in,
  input  wire logic [2:0] energy_tick_in,
  input  wire reg_req_t   reg_req_in,
  output reg_rsp_t        reg_rsp_out,
  output logic            converter_clock_out,
  output logic            remote_reset_n_out,
  output logic            sync_out,
  output logic            phase_a_select_out,
  output logic            phase_b_select_out,
  output logic            phase_c_select_out,
  output logic            neutral_select_out,
  output logic            interrupt_line_one_n_out,
  output logic            dsp_run_out,
  output logic            spi_active_out,
  output logic [2:0]      pulse_out_disable_out,
  output logic            ram_protect_out
);

  typedef enum logic [2:0] {ST_OFF, ST_WARM, ST_SEQ, ST_LOWPWR, ST_RUN} state_t;

  state_t      state_r;
  state_t      state_nxt;
  seq_kind_t   kind_r;
  seq_kind_t   kind_nxt;
  logic [11:0] cnt_r;
  logic [11:0] cnt_nxt;
  logic        sup_meta_r;
  logic        sup_ok_r;
  logic        pwrup_r;
  logic [1:0]  div_r;
  logic        conv_clk_r;
  logic        rrst_n_r;
  logic        sync_r;
  logic        sel_r;
  logic        rst_done_r;
  logic        irq_n_r;
  logic [15:0] maincfg_r;
  logic [7:0]  remctl_r;
  logic [15:0] run_r;
  logic [15:0] pulse_r;
  logic        key1_r;
  logic        protect_r;
  logic        lock_r;
  logic        spi_r;
  logic [31:0] gain_r [4];
  logic [31:0] energy_r [3];
  reg_rsp_t    rsp_r;
  logic [31:0] rdata;
  logic        wr;
  logic        rd;
  logic        soft_go;
  logic        seq_last;
  logic        seq_end;
  logic        regs_clr;
  logic        clock_on;

  localparam logic [11:0] WARM_LAST = 12'(WARM_CYC - 1);
  localparam logic [11:0] SEQ_LAST  = 12'(SEQ_CYC - 1);
  localparam logic [15:0] GAIN_ADDR [4] = '{ADDR_GAIN_A, ADDR_GAIN_B, ADDR_GAIN_C, ADDR_GAIN_N};
  localparam logic [15:0] EN_ADDR   [3] = '{ADDR_ENERGY_A, ADDR_ENERGY_B, ADDR_ENERGY_C};

  assign wr       = reg_req_in.wr;
  assign rd       = reg_req_in.rd;
  // soft reset only taken from normal running, so sequences never overlap
  // R8: soft reset request
  assign soft_go  = (state_r == ST_RUN) && wr && (reg_req_in.addr == ADDR_MAINCFG)
                    && reg_req_in.wdata[SOFT_RST_BIT];
  assign seq_last = (state_r == ST_SEQ) && (cnt_r == SEQ_LAST);
  assign seq_end  = seq_last && (kind_r != SEQ_REMOTE);
  // registers return to defaults on soft reset or loss of supply
  assign regs_clr = soft_go || !sup_ok_r;

  // supply monitor comes from outside, two flops before use
  always_ff @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      sup_meta_r <= 1'b0;
      sup_ok_r   <= 1'b0;
    end
    else
    begin
      sup_meta_r <= supply_ok_in;
      sup_ok_r   <= sup_meta_r;
    end
  end

  always_comb
  begin
    state_nxt = state_r;
    kind_nxt  = kind_r;
    cnt_nxt   = cnt_r + 12'h001;
    case (state_r)
      ST_OFF:
      begin
        cnt_nxt = 12'h000;
        if (sup_ok_r)
        begin
          // R22: power-up warms the remotes first
          if (pwrup_r)
          begin
            state_nxt = ST_WARM;
          end
          else
          begin
            // R2: release of hardware reset
            state_nxt = ST_SEQ;
            kind_nxt  = SEQ_HARD;
          end
        end
      end
      ST_WARM:
      begin
        // R22: 20 us wait
        if (cnt_r == WARM_LAST)
        begin
          state_nxt = ST_SEQ;
          kind_nxt  = SEQ_CHIP;
          cnt_nxt   = 12'h000;
        end
      end
      ST_SEQ:
      begin
        // R24: release after eight periods
        if (seq_last)
        begin
          state_nxt = ST_RUN;
        end
      end
      ST_LOWPWR:
      begin
        cnt_nxt = 12'h000;
        // R13: leave low power
        if (!remctl_r[CLK_DIS_BIT])
        begin
          state_nxt = ST_RUN;
        end
      end
      ST_RUN:
      begin
        cnt_nxt = 12'h000;
        if (soft_go)
        begin
          state_nxt = ST_SEQ;
          kind_nxt  = SEQ_CHIP;
        end
        else if (remctl_r[REMOTE_RST_BIT] && remctl_r[CLK_DIS_BIT])
        begin
          state_nxt = ST_LOWPWR;
        end
        else if (remctl_r[REMOTE_RST_BIT])
        begin
          // R11: remote-only sequence
          state_nxt = ST_SEQ;
          kind_nxt  = SEQ_REMOTE;
        end
      end
      default:
      begin
        state_nxt = ST_OFF;
      end
    endcase
    if (!sup_ok_r)
    begin
      state_nxt = ST_OFF;
    end
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      state_r <= ST_OFF;
      kind_r  <= SEQ_HARD;
      cnt_r   <= 12'h000;
    end
    else
    begin
      state_r <= state_nxt;
      kind_r  <= kind_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  // a hardware reset alone is not a power-up; supply loss marks one
  // the synchroniser reads low just after reset, so off state is ignored
  always_ff @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      pwrup_r <= 1'b0;
    end
    else if (!sup_ok_r && (state_r != ST_OFF))
    begin
      pwrup_r <= 1'b1;
    end
    else if (state_r == ST_WARM)
    begin
      pwrup_r <= 1'b0;
    end
  end

  // R3: clock stopped in hardware sequence and low power
  // R10: clock kept in soft and remote sequences
  assign clock_on = (state_nxt == ST_WARM) || (state_nxt == ST_RUN)
                    || ((state_nxt == ST_SEQ) && (kind_nxt != SEQ_HARD));

  // R1: async reset drives the remote-facing pins high
  always_ff @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      div_r      <= 2'h0;
      conv_clk_r <= 1'b1;
      rrst_n_r   <= 1'b1;
      sync_r     <= 1'b1;
      sel_r      <= 1'b1;
    end
    else
    begin
      // R24: free-running divide by four
      div_r      <= div_r + 2'h1;
      conv_clk_r <= clock_on ? div_r[1] : 1'b1;
      // R2: remote reset low while toggling
      rrst_n_r   <= !((state_nxt == ST_SEQ) || (state_nxt == ST_LOWPWR));
      sync_r     <= (state_nxt != ST_RUN);
      // R23: idle high keeps the remotes on temperature
      sel_r      <= (state_nxt == ST_SEQ) ? !cnt_nxt[1] : 1'b1;
    end
  end

  // R4: flag cleared by any chip reset, set when it ends
  // R5: set wins over a same-cycle clear
  always_ff @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      rst_done_r <= 1'b0;
      irq_n_r    <= 1'b1;
    end
    else
    begin
      if (seq_end)
      begin
        rst_done_r <= 1'b1;
      end
      else if (regs_clr || (wr && (reg_req_in.addr == ADDR_FLAGS1)
                            && reg_req_in.wdata[RST_DONE_BIT]))
      begin
        rst_done_r <= 1'b0;
      end
      // R6: no mask on this interrupt
      irq_n_r <= !rst_done_r;
    end
  end

  // R9: soft reset bit never stored, reads high only during the soft reset and power-up sequences
  always_ff @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      maincfg_r <= MAINCFG_RST;
      run_r     <= RUN_RST;
      pulse_r   <= PULSE_RST;
    end
    else if (regs_clr)
    begin
      // R7: DSP idle, defaults restored
      maincfg_r <= MAINCFG_RST;
      run_r     <= RUN_RST;
      pulse_r   <= PULSE_RST;
    end
    else if (wr)
    begin
      if (reg_req_in.addr == ADDR_MAINCFG)
      begin
        maincfg_r <= reg_req_in.wdata[15:0] & ~(16'h0001 << SOFT_RST_BIT);
      end
      if (reg_req_in.addr == ADDR_RUN)
      begin
        run_r <= reg_req_in.wdata[15:0];
      end
      // R21: pulse disable bits
      if (reg_req_in.addr == ADDR_PULSE)
      begin
        pulse_r <= reg_req_in.wdata[15:0];
      end
    end
  end

  // R11: self-clear at sequence end; a new write of one wins
  always_ff @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      remctl_r <= REMCTL_RST;
    end
    else if (regs_clr)
    begin
      remctl_r <= REMCTL_RST;
    end
    else if (wr && (reg_req_in.addr == ADDR_REMCTL))
    begin
      remctl_r <= reg_req_in.wdata[7:0];
    end
    else if (seq_last && (kind_r == SEQ_REMOTE))
    begin
      remctl_r[REMOTE_RST_BIT] <= 1'b0;
    end
  end

  // R19: second key only counts right after the first
  always_ff @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      key1_r    <= 1'b0;
      protect_r <= 1'b0;
    end
    else if (regs_clr)
    begin
      key1_r    <= 1'b0;
      protect_r <= 1'b0;
    end
    else if (wr)
    begin
      key1_r <= (reg_req_in.addr == ADDR_KEY1) && (reg_req_in.wdata[7:0] == KEY1_VALUE);
      if (key1_r && (reg_req_in.addr == ADDR_KEY2) && (reg_req_in.wdata[7:0] == KEY2_VALUE))
      begin
        protect_r <= 1'b1;
      end
    end
  end

  // R16: lock survives soft reset, cleared by hardware reset or supply loss
  // R8: unlocked port falls back to I2C on soft reset
  always_ff @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      lock_r <= 1'b0;
      spi_r  <= 1'b0;
    end
    else if (!sup_ok_r)
    begin
      lock_r <= 1'b0;
      spi_r  <= 1'b0;
    end
    else
    begin
      if (soft_go && !lock_r)
      begin
        spi_r <= 1'b0;
      end
      else if (!lock_r && spi_request_in)
      begin
        spi_r <= 1'b1;
      end
      if (wr && (reg_req_in.addr == ADDR_PORTLOCK) && (spi_r || reg_req_in.wdata[LOCK_BIT]))
      begin
        lock_r <= 1'b1;
      end
    end
  end

  // RAM-based gains; writes dropped once protection is armed
  for (genvar g = 0; g < 4; g++)
  begin : g_gain
    always_ff @(posedge clk_sys_in or negedge nrst_in)
    begin
      if (!nrst_in)
      begin
        gain_r[g] <= GAIN_RST;
      end
      else if (regs_clr)
      begin
        gain_r[g] <= GAIN_RST;
      end
      else if (wr && !protect_r && (reg_req_in.addr == GAIN_ADDR[g]))
      begin
        gain_r[g] <= reg_req_in.wdata;
      end
    end
  end

  // R20: read clears; a tick in the read cycle is kept
  for (genvar e = 0; e < 3; e++)
  begin : g_energy
    always_ff @(posedge clk_sys_in or negedge nrst_in)
    begin
      if (!nrst_in)
      begin
        energy_r[e] <= 32'h0000_0000;
      end
      else if (regs_clr)
      begin
        energy_r[e] <= 32'h0000_0000;
      end
      else
      begin
        energy_r[e] <= ((rd && (reg_req_in.addr == EN_ADDR[e])) ? 32'h0000_0000 : energy_r[e])
                       + {31'h0000_0000, energy_tick_in[e]};
      end
    end
  end

  always_comb
  begin
    rdata = 32'h0000_0000;
    case (reg_req_in.addr)
      ADDR_GAIN_A:   rdata = gain_r[0];
      ADDR_GAIN_B:   rdata = gain_r[1];
      ADDR_GAIN_C:   rdata = gain_r[2];
      ADDR_GAIN_N:   rdata = gain_r[3];
      ADDR_RUN:      rdata = {16'h0000, run_r};
      ADDR_FLAGS1:   rdata = {16'h0000, rst_done_r, 15'h0000};
      ADDR_PULSE:    rdata = {16'h0000, pulse_r};
      ADDR_MAINCFG:
      begin
        rdata = {16'h0000, maincfg_r};
        rdata[SOFT_RST_BIT] = (state_r == ST_SEQ) && (kind_r == SEQ_CHIP);
      end
      // R12: host polls this bit
      ADDR_REMCTL:   rdata = {24'h000000, remctl_r};
      ADDR_PORTLOCK: rdata = {31'h0000_0000, lock_r};
      ADDR_ENERGY_A: rdata = energy_r[0];
      ADDR_ENERGY_B: rdata = energy_r[1];
      ADDR_ENERGY_C: rdata = energy_r[2];
      default:       rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      rsp_r <= '0;
    end
    else
    begin
      rsp_r.valid <= rd;
      rsp_r.rdata <= rd ? rdata : 32'h0000_0000;
    end
  end

  assign reg_rsp_out              = rsp_r;
  assign converter_clock_out      = conv_clk_r;
  assign remote_reset_n_out       = rrst_n_r;
  assign sync_out                 = sync_r;
  assign phase_a_select_out       = sel_r;
  assign phase_b_select_out       = sel_r;
  assign phase_c_select_out       = sel_r;
  assign neutral_select_out       = sel_r;
  assign interrupt_line_one_n_out = irq_n_r;
  assign dsp_run_out              = run_r[RUN_BIT];
  assign spi_active_out           = spi_r;
  assign pulse_out_disable_out    = pulse_r[PULSE_DIS_LSB +: 3];
  assign ram_protect_out          = protect_r;

endmodule

// ---- pkg/metering_seq_pkg.sv ----
package metering_seq_pkg;

  // clocking and timing
  localparam int unsigned CLK_MHZ        = 100;
  localparam int unsigned HW_HOLD_MIN_NS = 10000;
  localparam int unsigned WARM_NS        = 20000;
  localparam int unsigned WARM_CYC       = (WARM_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CONV_DIV       = 4;
  localparam int unsigned TOGGLE_COUNT   = 8;
  localparam int unsigned SEQ_CYC        = CONV_DIV * TOGGLE_COUNT;

  // register offsets
  localparam logic [15:0] ADDR_GAIN_A   = 16'h4380;
  localparam logic [15:0] ADDR_GAIN_B   = 16'h4383;
  localparam logic [15:0] ADDR_GAIN_C   = 16'h4386;
  localparam logic [15:0] ADDR_GAIN_N   = 16'h4389;
  localparam logic [15:0] ADDR_RAM_LO   = 16'h4380;
  localparam logic [15:0] ADDR_RAM_HI   = 16'h43BF;
  localparam logic [15:0] ADDR_RUN      = 16'hE228;
  localparam logic [15:0] ADDR_FLAGS1   = 16'hE503;
  localparam logic [15:0] ADDR_PULSE    = 16'hE610;
  localparam logic [15:0] ADDR_MAINCFG  = 16'hE618;
  localparam logic [15:0] ADDR_REMCTL   = 16'hE708;
  localparam logic [15:0] ADDR_KEY2     = 16'hE7E3;
  localparam logic [15:0] ADDR_KEY1     = 16'hE7FE;
  localparam logic [15:0] ADDR_PORTLOCK = 16'hEA00;
  localparam logic [15:0] ADDR_ENERGY_A = 16'hE400;
  localparam logic [15:0] ADDR_ENERGY_B = 16'hE401;
  localparam logic [15:0] ADDR_ENERGY_C = 16'hE402;

  // field positions
  localparam int unsigned RST_DONE_BIT   = 15;
  localparam int unsigned SOFT_RST_BIT   = 7;
  localparam int unsigned REMOTE_RST_BIT = 7;
  localparam int unsigned CLK_DIS_BIT    = 6;
  localparam int unsigned LOCK_BIT       = 0;
  localparam int unsigned RUN_BIT        = 0;
  localparam int unsigned PULSE_DIS_LSB  = 9;

  // keys and reset values
  localparam logic [7:0]  KEY1_VALUE    = 8'hAD;
  localparam logic [7:0]  KEY2_VALUE    = 8'h80;
  localparam logic [15:0] PULSE_RST     = 16'h0E00;
  localparam logic [15:0] MAINCFG_RST   = 16'h0000;
  localparam logic [7:0]  REMCTL_RST    = 8'h00;
  localparam logic [15:0] RUN_RST       = 16'h0000;
  localparam logic [31:0] GAIN_RST      = 32'h0000_0000;

  typedef enum logic [1:0] {SEQ_HARD, SEQ_CHIP, SEQ_REMOTE} seq_kind_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [31:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] rdata;
  } reg_rsp_t;

endpackage

// ---- testbench/meter_seq_sva.sv ----
`timescale 1ns/100ps
module meter_seq_checker
  import metering_seq_pkg::*;
(
  input wire logic     clk_sys_in,
  input wire logic     nrst_in,
  input wire reg_req_t reg_req_in,
  input wire reg_rsp_t reg_rsp_out,
  input wire logic     converter_clock_out,
  input wire logic     remote_reset_n_out,
  input wire logic     sync_out,
  input wire logic     phase_a_select_out,
  input wire logic     phase_b_select_out,
  input wire logic     phase_c_select_out,
  input wire logic     neutral_select_out,
  input wire logic     interrupt_line_one_n_out,
  input wire logic     dsp_run_out
);
  logic [7:0] low_cnt_r;
  logic [7:0] fall_cnt_r;
  logic       sel_d_r;
  logic       sel_all;
  logic       flag_clr;
  logic       soft_wr;
  logic       rem_wr;
  assign sel_all  = phase_a_select_out & phase_b_select_out & phase_c_select_out
                    & neutral_select_out;
  assign flag_clr = reg_req_in.wr && reg_req_in.addr == ADDR_FLAGS1
                    && reg_req_in.wdata[RST_DONE_BIT];
  assign soft_wr  = reg_req_in.wr && reg_req_in.addr == ADDR_MAINCFG
                    && reg_req_in.wdata[SOFT_RST_BIT];
  assign rem_wr   = reg_req_in.wr && reg_req_in.addr == ADDR_REMCTL
                    && reg_req_in.wdata[REMOTE_RST_BIT] && !reg_req_in.wdata[CLK_DIS_BIT];
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!nrst_in);
  // low time and select falls of one remote reset; low power gives no falls
  always_ff @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      low_cnt_r  <= 8'h00;
      fall_cnt_r <= 8'h00;
      sel_d_r    <= 1'b1;
    end
    else
    begin
      sel_d_r    <= phase_a_select_out;
      low_cnt_r  <= remote_reset_n_out ? 8'h00 : low_cnt_r + 8'h01;
      fall_cnt_r <= remote_reset_n_out ? 8'h00 :
                    fall_cnt_r + 8'(sel_d_r & ~phase_a_select_out);
    end
  end
  sequence s_sel_low_high;
    !phase_a_select_out ##1 phase_a_select_out;
  endsequence
  sequence s_irq_up;
    ##2 interrupt_line_one_n_out;
  endsequence
  property p_hw_hold;
    $rose(nrst_in) |-> converter_clock_out && sync_out && remote_reset_n_out && sel_all
                       && !dsp_run_out;
  endproperty
  property p_seq_len;
    $rose(remote_reset_n_out) && fall_cnt_r != 8'h00 |-> fall_cnt_r == 8'h08
                                                        && low_cnt_r == 8'h20;
  endproperty
  property p_sel_idle;
    remote_reset_n_out |-> sel_all;
  endproperty
  property p_sel_pulse;
    $fell(phase_a_select_out) |-> ##1 s_sel_low_high;
  endproperty
  property p_sel_same;
    phase_a_select_out == phase_b_select_out && phase_b_select_out == phase_c_select_out
    && phase_c_select_out == neutral_select_out;
  endproperty
  property p_clk_resume;
    $rose(remote_reset_n_out) |-> ##[1:8] !converter_clock_out;
  endproperty
  property p_irq_set;
    $fell(interrupt_line_one_n_out) |-> remote_reset_n_out && sel_all;
  endproperty
  property p_irq_stay;
    !interrupt_line_one_n_out && !flag_clr && !$past(flag_clr) |=> !interrupt_line_one_n_out;
  endproperty
  property p_irq_clear;
    flag_clr && !interrupt_line_one_n_out |-> s_irq_up;
  endproperty
  property p_rd_rsp;
    reg_rsp_out.valid == $past(reg_req_in.rd)
    && (reg_rsp_out.valid || reg_rsp_out.rdata == 32'h0);
  endproperty
  property p_soft_go;
    soft_wr |-> ##[1:4] (!remote_reset_n_out && !dsp_run_out);
  endproperty
  property p_remote_go;
    rem_wr |-> ##[1:3] !remote_reset_n_out;
  endproperty
  a_hw_hold: assert property (p_hw_hold)
    else $error("reset levels wrong");
  a_seq_len: assert property (p_seq_len)
    else $error("sequence length wrong");
  a_sel_idle: assert property (p_sel_idle)
    else $error("selects not high");
  a_sel_pulse: assert property (p_sel_pulse)
    else $error("select low time wrong");
  a_sel_same: assert property (p_sel_same)
    else $error("selects differ");
  a_clk_resume: assert property (p_clk_resume)
    else $error("clock did not resume");
  a_irq_set: assert property (p_irq_set)
    else $error("interrupt during sequence");
  a_irq_stay: assert property (p_irq_stay)
    else $error("interrupt released early");
  a_irq_clear: assert property (p_irq_clear)
    else $error("interrupt not released");
  a_rd_rsp: assert property (p_rd_rsp)
    else $error("read answer wrong");
  a_soft_go: assert property (p_soft_go)
    else $error("soft reset not started");
  a_remote_go: assert property (p_remote_go)
    else $error("remote reset not started");
endmodule

// ---- testbench/remote_converter_model.sv ----
`timescale 1ns/100ps
module remote_converter_model
(
  input  wire logic remote_clock_in,
  input  wire logic remote_reset_n_in,
  input  wire logic select_in,
  output int        toggles_out,
  output int        clocks_in_reset_out
);
  logic rst_q = 1'b1;
  logic sel_q = 1'b1;
  logic clk_q = 1'b1;
  // counts restart at each reset entry, so they describe the last sequence only
  // one process keeps each count single-driven
  always @(remote_reset_n_in or select_in or remote_clock_in)
  begin
    if (rst_q && !remote_reset_n_in)
    begin
      toggles_out = 0;
      clocks_in_reset_out = 0;
    end
    if (sel_q && !select_in && !remote_reset_n_in)
      toggles_out = toggles_out + 1;
    if (!clk_q && remote_clock_in && !remote_reset_n_in)
      clocks_in_reset_out = clocks_in_reset_out + 1;
    rst_q = remote_reset_n_in;
    sel_q = select_in;
    clk_q = remote_clock_in;
  end
endmodule

// ---- testbench/tb.sv ----
`timescale 1ns/100ps
bind metering_reset_init_sequencer meter_seq_checker u_chk (
  .clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .reg_req_in(reg_req_in),
  .reg_rsp_out(reg_rsp_out), .converter_clock_out(converter_clock_out),
  .remote_reset_n_out(remote_reset_n_out), .sync_out(sync_out),
  .phase_a_select_out(phase_a_select_out), .phase_b_select_out(phase_b_select_out),
  .phase_c_select_out(phase_c_select_out), .neutral_select_out(neutral_select_out),
  .interrupt_line_one_n_out(interrupt_line_one_n_out), .dsp_run_out(dsp_run_out));
module tb
  import metering_seq_pkg::*;
;
  logic        clk_sys_in = 1'b0;
  logic        nrst_in = 1'b0;
  logic        sup_ok = 1'b1;
  logic        spi_req = 1'b0;
  logic [2:0]  tick = 3'h0;
  reg_req_t    req = '0;
  reg_rsp_t    rsp;
  logic        cclk, rrst_n, sync_o, sel_a, sel_b, sel_c, sel_n;
  logic        irq_n, dsp_run, spi_act, prot;
  logic [2:0]  pulse_dis;
  logic [31:0] rd_val;
  int          toggles, clk_in_rst, error_cnt, compares, cyc, n;
  metering_reset_init_sequencer DUT (
    .clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .supply_ok_in(sup_ok),
    .spi_request_in(spi_req), .energy_tick_in(tick), .reg_req_in(req), .reg_rsp_out(rsp),
    .converter_clock_out(cclk), .remote_reset_n_out(rrst_n), .sync_out(sync_o),
    .phase_a_select_out(sel_a), .phase_b_select_out(sel_b), .phase_c_select_out(sel_c),
    .neutral_select_out(sel_n), .interrupt_line_one_n_out(irq_n), .dsp_run_out(dsp_run),
    .spi_active_out(spi_act), .pulse_out_disable_out(pulse_dis), .ram_protect_out(prot));
  remote_converter_model u_remote (
    .remote_clock_in(cclk), .remote_reset_n_in(rrst_n), .select_in(sel_a),
    .toggles_out(toggles), .clocks_in_reset_out(clk_in_rst));
  initial
  begin
    forever #5 clk_sys_in = ~clk_sys_in;
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // a hang counts as a mismatch
  always @(posedge clk_sys_in)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      report_and_stop();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_b(input string nm, input logic e, input logic g);
    compares++;
    if (g !== e)
    begin
      error_cnt++;
      $display("ERROR %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic wr_reg(input logic [15:0] a, input logic [31:0] d);
    req.wr    <= 1'b1;
    req.addr  <= a;
    req.wdata <= d;
    @(posedge clk_sys_in);
    req.wr <= 1'b0;
    @(posedge clk_sys_in);
  endtask
  task automatic rd_reg(input logic [15:0] a, output logic [31:0] d);
    req.rd   <= 1'b1;
    req.addr <= a;
    @(posedge clk_sys_in);
    req.rd <= 1'b0;
    #1;
    chk_b("read valid", 1'b1, rsp.valid);
    d = rsp.rdata;
    @(posedge clk_sys_in);
  endtask
  task automatic chk_rd(input string nm, input logic [15:0] a, input logic [31:0] m,
                        input logic [31:0] e);
    logic [31:0] v;
    rd_reg(a, v);
    chk(nm, e, v & m);
  endtask
  // waits are bounded so a stuck sequence cannot hang the run
  task automatic wait_irq(input logic lvl, input int lim);
    n = 0;
    while (irq_n !== lvl && n < lim)
    begin
      @(posedge clk_sys_in);
      n++;
    end
    chk_b("irq level", lvl, irq_n);
  endtask
  initial
  begin
    repeat (2) @(posedge clk_sys_in);
    chk("reset pins", 32'h7F, 32'({cclk, sync_o, rrst_n, sel_a, sel_b, sel_c, sel_n}));
    chk_b("reset irq", 1'b1, irq_n);
    repeat (2) @(posedge clk_sys_in);
    nrst_in <= 1'b1;
    wait_irq(1'b0, 2500);
    chk("hw toggles", 32'h8, toggles);
    chk_b("sync run", 1'b0, sync_o);
    chk_rd("flag set", ADDR_FLAGS1, 32'h8000, 32'h8000);
    chk_rd("cfg dflt", ADDR_MAINCFG, 32'hFFFF, {16'h0, MAINCFG_RST});
    chk_rd("pulse dflt", ADDR_PULSE, 32'hFFFF, {16'h0, PULSE_RST});
    chk_rd("run dflt", ADDR_RUN, 32'hFFFF, {16'h0, RUN_RST});
    chk_b("port i2c", 1'b0, spi_act);
    spi_req <= 1'b1;
    @(posedge clk_sys_in);
    spi_req <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    chk_b("spi sel", 1'b1, spi_act);
    wr_reg(ADDR_PORTLOCK, 32'h0);
    wr_reg(ADDR_FLAGS1, 32'h8000);
    repeat (2) @(posedge clk_sys_in);
    chk_b("irq clear", 1'b1, irq_n);
    chk_rd("flag clr", ADDR_FLAGS1, 32'h8000, 32'h0);
    wr_reg(ADDR_GAIN_A, 32'h1234_5678);
    repeat (3) wr_reg(ADDR_GAIN_N, 32'h0000_0100);
    wr_reg(ADDR_RUN, 32'h1);
    wr_reg(ADDR_KEY1, {24'h0, KEY1_VALUE});
    wr_reg(ADDR_KEY2, {24'h0, KEY2_VALUE});
    wr_reg(ADDR_GAIN_A, 32'h0BAD_0BAD);
    chk_rd("gain lock", ADDR_GAIN_A, 32'hFFFF_FFFF, 32'h1234_5678);
    chk_b("protect", 1'b1, prot);
    for (int i = 0; i < 3; i++)
    begin
      tick[i] <= 1'b1;
      @(posedge clk_sys_in);
      tick[i] <= 1'b0;
      @(posedge clk_sys_in);
      chk_rd("energy", ADDR_ENERGY_A + 16'(i), 32'hFFFF_FFFF, 32'h1);
      chk_rd("energy clr", ADDR_ENERGY_A + 16'(i), 32'hFFFF_FFFF, 32'h0);
    end
    wr_reg(ADDR_PULSE, 32'h0);
    chk("pulse en", 32'h0, 32'(pulse_dis));
    chk_b("dsp run", 1'b1, dsp_run);
    wr_reg(ADDR_REMCTL, 32'h80);
    rd_val = 32'h80;
    n = 0;
    while (rd_val[REMOTE_RST_BIT] !== 1'b0 && n < 40)
    begin
      rd_reg(ADDR_REMCTL, rd_val);
      n++;
    end
    chk_b("remote bit", 1'b0, rd_val[REMOTE_RST_BIT]);
    chk("rem toggles", 32'h8, toggles);
    chk_b("irq kept", 1'b1, irq_n);
    chk_b("dsp kept", 1'b1, dsp_run);
    wr_reg(ADDR_REMCTL, 32'hC0);
    repeat (12) @(posedge clk_sys_in);
    repeat (4)
    begin
      @(posedge clk_sys_in);
      chk("low power", 32'h2, 32'({cclk, rrst_n}));
    end
    wr_reg(ADDR_REMCTL, 32'h0);
    n = 0;
    while (rrst_n !== 1'b1 && n < 60)
    begin
      @(posedge clk_sys_in);
      n++;
    end
    chk_b("lp exit", 1'b1, rrst_n);
    chk_b("lp regs", 1'b1, dsp_run);
    wr_reg(ADDR_MAINCFG, 32'h80);
    wait_irq(1'b0, 300);
    chk("soft toggles", 32'h8, toggles);
    chk_b("soft clock", 1'b1, clk_in_rst > 0);
    chk_rd("soft bit", ADDR_MAINCFG, 32'h80, 32'h0);
    chk_b("dsp idle", 1'b0, dsp_run);
    chk("pulse back", 32'h7, 32'(pulse_dis));
    chk_b("spi kept", 1'b1, spi_act);
    wr_reg(ADDR_FLAGS1, 32'h8000);
    nrst_in <= 1'b0;
    repeat (HW_HOLD_MIN_NS * CLK_MHZ / 1000) @(posedge clk_sys_in);
    nrst_in <= 1'b1;
    wait_irq(1'b0, 2500);
    chk("hw clock", 32'h0, clk_in_rst);
    chk_b("spi unlock", 1'b0, spi_act);
    chk_b("hw dsp idle", 1'b0, dsp_run);
    wr_reg(ADDR_FLAGS1, 32'h8000);
    sup_ok <= 1'b0;
    repeat (4) @(posedge clk_sys_in);
    sup_ok <= 1'b1;
    wait_irq(1'b0, 2500);
    chk_b("warm time", 1'b1, n > WARM_CYC);
    chk_b("warm clock", 1'b1, clk_in_rst > 0);
    report_and_stop();
  end
endmodule
